// ===== hw/bcs_pkg.sv
// package: register map, fields, timing constants and carrier types
package bcs_pkg;
    localparam int CLK_MHZ = 100;
    // times in ns as printed
    localparam int T_QUAL_NS = 40000;
    localparam int T_DEGLITCH_NS = 128000;
    localparam int T_BIAS_NS = 400000;
    localparam int T_STEP_UNIT_NS = 2000;
    localparam int T_ARM_SHORT_NS = 25000;
    localparam int T_ARM_LONG_NS = 40000;
    localparam int T_RETRY_NS = 20000000;
    localparam int QUAL_CYC = T_QUAL_NS * CLK_MHZ / 1000;
    localparam int DEGLITCH_CYC = T_DEGLITCH_NS * CLK_MHZ / 1000;
    localparam int BIAS_CYC = T_BIAS_NS * CLK_MHZ / 1000;
    localparam int STEP_UNIT_CYC = T_STEP_UNIT_NS * CLK_MHZ / 1000;
    localparam int ARM_SHORT_CYC = T_ARM_SHORT_NS * CLK_MHZ / 1000;
    localparam int ARM_LONG_CYC = T_ARM_LONG_NS * CLK_MHZ / 1000;
    localparam int RETRY_CYC = T_RETRY_NS / 1000 * CLK_MHZ;
    localparam int CW = 24;
    // register byte addresses
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_RAMP = 8'h08;
    localparam logic [7:0] ADR_PGCFG = 8'h0C;
    localparam logic [7:0] ADR_CTRL = 8'h18;
    localparam logic [7:0] ADR_TGT_A = 8'h20;
    localparam logic [7:0] ADR_TGT_B = 8'h24;
    // field positions
    localparam int F_PGOOD = 5;
    localparam int F_WIDEBAND = 1;
    localparam int F_STEP_LO = 2;
    localparam int F_QUIET_AUDIO_TIMEOUT_SEL = 6;
    localparam int F_POL = 0;
    localparam int F_FLT_SHDN = 3;
    localparam int F_EN = 0;
    localparam int F_FORCE = 1;
    localparam int F_SELFOL = 2;
    localparam int F_BLEED = 3;
    localparam int F_RAMP_EN = 4;
    localparam int F_ARM_EN = 5;
    // reset values and wide-band limit
    localparam logic [7:0] RST_RAMP = 8'h04;
    localparam logic [7:0] RST_PGCFG = 8'h01;
    localparam logic [7:0] RST_CTRL = 8'h19;
    localparam logic [7:0] RST_TGT_A = 8'h46;
    localparam logic [7:0] RST_TGT_B = 8'h4B;
    localparam logic [7:0] OUT_WB_LIM = 8'h4F;

    typedef enum logic [4:0] {
        BCS_OFF = 5'h01,
        BCS_BIAS = 5'h02,
        BCS_RAMP = 5'h04,
        BCS_RUN = 5'h08,
        BCS_FAULT = 5'h10
    } bcs_state_t;

    typedef struct packed {
        logic valley_clamp_level;
        logic supply_low_lockout;
        logic out_short;
        logic over_temp;
        logic out_above_93;
        logic idle;
        logic on_start;
    } bcs_sense_t;

    typedef struct packed {
        logic [7:0] target;
        logic pulse_skipping_mode;
        logic forced_continuous_mode;
        logic bleed;
        logic force_sync_on;
        logic wide_band_hint;
        logic running;
    } bcs_drive_t;
endpackage : bcs_pkg

// ===== hw/bcs_sequencer.sv
// buck start-up, ramp, power-ok and fault sequencer with wishbone registers
// Overview of operation
// - leave shutdown only with enable pin high and enable bit set
// - bleed on in shutdown and fault unless bleed bit cleared
// - soft-start uses ramp engine; ramp enable bit cannot bypass it
// - step time field resets to 4 us per step
// - wait 400 us bias delay before ramping, power-ok inactive
// - pulse skipping during start-up until ramp finishes
// - after ramp above 93 percent, 128 us de-glitch then power-ok
// - raising target drops power-ok until ramp and fresh de-glitch
// - lowering target keeps power-ok asserted only with ramp enable clear; with it set the ramp drops power-ok
// - below 93 percent over 128 us drops power-ok; recover via de-glitch
// - enable low drops power-ok at once
// - power-ok inactive in fault, dropped when fault qualifies
// - polarity bit picks power-ok level; default active releases pin
// - status bit reads one while power-ok active
// - valley clamp held 40 us enters fault
// - supply low held 40 us enters fault
// - output short held 40 us in run state enters fault
// - over-temperature held 40 us enters fault
// - quiet audio mode forces sync switch after 25 or 40 us idle
// - target steps one code at a time toward the new value
// - step dwell comes from field bits 4 to 2
// - code n gives 2*(n+1) us per step
// - ramp enable clear makes changes immediate, soft-start still steps
// - continuous mode by force bit, or select input with follow bit
// - output short or clamp fault retries every 20 ms, or shuts down
module bcs_sequencer (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic enable_pin,
    input wire logic vsel,
    input wire bcs_pkg::bcs_sense_t sense,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic power_ok_output_o,
    output logic power_ok_output_oe_b,
    output bcs_pkg::bcs_drive_t drive
);
    import bcs_pkg::*;

    bcs_state_t state_r;
    logic [7:0] ramp_r, pgcfg_r, ctrl_r, tgt_a_r, tgt_b_r;
    logic [7:0] target_r;
    logic [CW-1:0] seq_cnt_r;
    logic [CW-1:0] dg_cnt_r;
    logic [CW-1:0] low_cnt_r;
    logic [CW-1:0] arm_cnt_r;
    logic [CW-1:0] q_cnt_r [4];
    logic [3:0] q_hit;
    logic pg_r;
    logic dg_run_r;
    logic retry_r;
    logic fault_now;
    logic retry_kind;
    logic wr;
    logic en_ok;
    logic [7:0] goal;
    logic [CW-1:0] step_cyc;
    logic [CW-1:0] arm_lim;
    logic [3:0] flt_in;

    assign en_ok = enable_pin & ctrl_r[F_EN];
    assign goal = vsel ? tgt_b_r : tgt_a_r;
    assign step_cyc = CW'((32'(ramp_r[F_STEP_LO+:3]) + 32'd1)
        * STEP_UNIT_CYC);
    assign arm_lim = ramp_r[F_QUIET_AUDIO_TIMEOUT_SEL] ? CW'(ARM_LONG_CYC)
        : CW'(ARM_SHORT_CYC);
    assign flt_in = {sense.valley_clamp_level, sense.out_short,
        sense.supply_low_lockout, sense.over_temp};
    assign retry_kind = q_hit[3] | q_hit[2];
    assign fault_now = |q_hit;
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];

    // fault qualifiers, each restarts when its comparator drops
    for (genvar i = 0; i < 4; i++) begin : g_qual
        always_ff @(posedge clk) begin
            if (!rst_b) begin
                q_cnt_r[i] <= '0;
            end else if (ce) begin
                if (!flt_in[i] || state_r != BCS_RUN && i == 2) begin
                    q_cnt_r[i] <= '0;
                end else if (q_cnt_r[i] != CW'(QUAL_CYC)) begin
                    q_cnt_r[i] <= q_cnt_r[i] + 1'b1;
                end
            end
        end
        assign q_hit[i] = q_cnt_r[i] == CW'(QUAL_CYC);
    end

    // main sequence
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= BCS_OFF;
            seq_cnt_r <= '0;
            target_r <= '0;
            retry_r <= 1'b0;
        end else if (ce) begin
            unique case (state_r)
                BCS_OFF: begin
                    target_r <= '0;
                    seq_cnt_r <= '0;
                    if (en_ok) begin
                        state_r <= BCS_BIAS;
                    end
                end
                BCS_BIAS: begin
                    if (!en_ok) begin
                        state_r <= BCS_OFF;
                    end else if (seq_cnt_r == CW'(BIAS_CYC - 1)) begin
                        seq_cnt_r <= '0;
                        state_r <= BCS_RAMP;
                    end else begin
                        seq_cnt_r <= seq_cnt_r + 1'b1;
                    end
                end
                BCS_RAMP, BCS_RUN: begin
                    if (!en_ok) begin
                        state_r <= BCS_OFF;
                    end else if (fault_now) begin
                        seq_cnt_r <= '0;
                        retry_r <= retry_kind;
                        state_r <= BCS_FAULT;
                    end else if (target_r == goal) begin
                        seq_cnt_r <= '0;
                        state_r <= BCS_RUN;
                    end else if (state_r == BCS_RUN
                            && !ctrl_r[F_RAMP_EN]) begin
                        target_r <= goal;
                    end else if (seq_cnt_r >= step_cyc - 1'b1) begin
                        seq_cnt_r <= '0;
                        state_r <= BCS_RAMP;
                        target_r <= target_r < goal ? target_r + 1'b1
                            : target_r - 1'b1;
                    end else begin
                        seq_cnt_r <= seq_cnt_r + 1'b1;
                        state_r <= BCS_RAMP;
                    end
                end
                BCS_FAULT: begin
                    target_r <= '0;
                    if (!en_ok) begin
                        state_r <= BCS_OFF;
                    end else if (!retry_r || ctrl_r[F_FLT_SHDN]) begin
                        if (!fault_now) begin
                            state_r <= BCS_OFF;
                        end
                    end else if (seq_cnt_r == CW'(RETRY_CYC - 1)) begin
                        seq_cnt_r <= '0;
                        state_r <= BCS_BIAS;
                    end else begin
                        seq_cnt_r <= seq_cnt_r + 1'b1;
                    end
                end
                default: state_r <= BCS_OFF;
            endcase
        end
    end

    // power-ok de-glitch and low-output timers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pg_r <= 1'b0;
            dg_cnt_r <= '0;
            low_cnt_r <= '0;
        end else if (ce) begin
            if (state_r != BCS_RUN || !en_ok || fault_now
                    || goal > target_r) begin
                pg_r <= 1'b0;
                dg_cnt_r <= '0;
                low_cnt_r <= '0;
            end else if (pg_r) begin
                dg_cnt_r <= '0;
                if (sense.out_above_93) begin
                    low_cnt_r <= '0;
                end else if (low_cnt_r == CW'(DEGLITCH_CYC)) begin
                    pg_r <= 1'b0;
                end else begin
                    low_cnt_r <= low_cnt_r + 1'b1;
                end
            end else if (!sense.out_above_93) begin
                dg_cnt_r <= '0;
            end else if (dg_cnt_r == CW'(DEGLITCH_CYC - 1)) begin
                pg_r <= 1'b1;
                low_cnt_r <= '0;
            end else begin
                dg_cnt_r <= dg_cnt_r + 1'b1;
            end
        end
    end

    // quiet audio idle timer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            arm_cnt_r <= '0;
            drive.force_sync_on <= 1'b0;
        end else if (ce) begin
            drive.force_sync_on <= 1'b0;
            if (!ctrl_r[F_ARM_EN] || !sense.idle || sense.on_start
                    || state_r != BCS_RUN) begin
                arm_cnt_r <= '0;
            end else if (arm_cnt_r == arm_lim - 1'b1) begin
                arm_cnt_r <= '0;
                drive.force_sync_on <= 1'b1;
            end else begin
                arm_cnt_r <= arm_cnt_r + 1'b1;
            end
        end
    end

    // registered drive outputs
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            drive.target <= '0;
            drive.pulse_skipping_mode <= 1'b1;
            drive.forced_continuous_mode <= 1'b0;
            drive.bleed <= 1'b1;
            drive.wide_band_hint <= 1'b0;
            drive.running <= 1'b0;
            power_ok_output_o <= 1'b0;
            power_ok_output_oe_b <= 1'b1;
        end else if (ce) begin
            drive.target <= target_r;
            drive.running <= state_r == BCS_RAMP || state_r == BCS_RUN;
            drive.forced_continuous_mode <= state_r == BCS_RUN
                && (ctrl_r[F_FORCE] || vsel && ctrl_r[F_SELFOL]);
            drive.pulse_skipping_mode <= state_r != BCS_RUN;
            drive.bleed <= ctrl_r[F_BLEED]
                && (state_r == BCS_OFF || state_r == BCS_FAULT);
            drive.wide_band_hint <= tgt_a_r > OUT_WB_LIM
                && tgt_b_r > OUT_WB_LIM;
            power_ok_output_o <= 1'b0;
            // pin pulled low when enable asserted
            power_ok_output_oe_b <= pg_r ~^ pgcfg_r[F_POL];
        end
    end

    // wishbone slave, one registered ack per request, one cycle after strobe
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
            ramp_r <= RST_RAMP;
            pgcfg_r <= RST_PGCFG;
            ctrl_r <= RST_CTRL;
            tgt_a_r <= RST_TGT_A;
            tgt_b_r <= RST_TGT_B;
        end else if (ce) begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
            wb_dat_o <= '0;
            if (state_r == BCS_FAULT && retry_r && ctrl_r[F_FLT_SHDN]) begin
                ctrl_r[F_EN] <= 1'b0;
            end
            if (wr) begin
                unique case (wb_adr_i)
                    ADR_RAMP: ramp_r <= wb_dat_i[7:0];
                    ADR_PGCFG: pgcfg_r <= wb_dat_i[7:0];
                    ADR_CTRL: ctrl_r <= wb_dat_i[7:0];
                    ADR_TGT_A: tgt_a_r <= wb_dat_i[7:0];
                    ADR_TGT_B: tgt_b_r <= wb_dat_i[7:0];
                    default: ;
                endcase
            end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
                unique case (wb_adr_i)
                    ADR_STATUS: wb_dat_o[F_PGOOD] <= pg_r;
                    ADR_RAMP: wb_dat_o[7:0] <= ramp_r;
                    ADR_PGCFG: wb_dat_o[7:0] <= pgcfg_r;
                    ADR_CTRL: wb_dat_o[7:0] <= ctrl_r;
                    ADR_TGT_A: wb_dat_o[7:0] <= tgt_a_r;
                    ADR_TGT_B: wb_dat_o[7:0] <= tgt_b_r;
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end

    sequence s_bias_done;
        ce && state_r == BCS_BIAS && en_ok
            && seq_cnt_r == CW'(BIAS_CYC - 1);
    endsequence
    property p_en_gate;
        @(posedge clk) disable iff (!rst_b)
        ce && state_r == BCS_OFF && !en_ok |=> state_r == BCS_OFF;
    endproperty
    a_en_gate: assert property (p_en_gate)
        else $error("left shutdown without enable");
    property p_bias;
        @(posedge clk) disable iff (!rst_b)
        s_bias_done |=> state_r == BCS_RAMP && !pg_r;
    endproperty
    a_bias: assert property (p_bias)
        else $error("bias delay end not followed by ramp");
    property p_pg_off;
        @(posedge clk) disable iff (!rst_b)
        ce && (!en_ok || fault_now) |=> !pg_r;
    endproperty
    a_pg_off: assert property (p_pg_off)
        else $error("power ok held after enable low or fault");
    property p_up_drop;
        @(posedge clk) disable iff (!rst_b)
        ce && goal > target_r |=> !pg_r;
    endproperty
    a_up_drop: assert property (p_up_drop)
        else $error("power ok held on upward change");
    property p_pol;
        @(posedge clk) disable iff (!rst_b)
        ce |=> power_ok_output_oe_b == ($past(pg_r) ~^ $past(pgcfg_r[F_POL]));
    endproperty
    a_pol: assert property (p_pol)
        else $error("power ok pin level wrong");
    property p_step;
        @(posedge clk) disable iff (!rst_b)
        ce && $past(ce) && state_r == BCS_RAMP && $past(state_r) == BCS_RAMP
        |-> target_r - $past(target_r) inside {8'h00, 8'h01, 8'hFF};
    endproperty
    a_step: assert property (p_step)
        else $error("ramp jumped more than one code");
    property p_dcm;
        @(posedge clk) disable iff (!rst_b)
        ce && state_r == BCS_RAMP |=> drive.pulse_skipping_mode
            && !drive.forced_continuous_mode;
    endproperty
    a_dcm: assert property (p_dcm)
        else $error("continuous mode during ramp");
    property p_qual;
        @(posedge clk) disable iff (!rst_b)
        ce && fault_now && state_r == BCS_RUN && en_ok
            |=> state_r == BCS_FAULT;
    endproperty
    a_qual: assert property (p_qual)
        else $error("qualified fault not taken");
endmodule : bcs_sequencer

// ===== tb/bcs_analog_model.sv
// analog stage model: comparator levels from drive state and bench knobs
module bcs_analog_model (
    input wire logic clk,
    input wire bcs_pkg::bcs_drive_t drive,
    input wire logic droop,
    input wire logic clamp,
    input wire logic idle_req,
    output bcs_pkg::bcs_sense_t sense
);
    import bcs_pkg::*;
    // registered like a real comparator; output follows target when running
    always @(posedge clk) begin
        sense.valley_clamp_level <= clamp;
        sense.supply_low_lockout <= 1'b0;
        sense.out_short <= 1'b0;
        sense.over_temp <= 1'b0;
        sense.out_above_93 <= drive.running && !droop;
        sense.idle <= drive.running && idle_req;
        sense.on_start <= drive.running && !idle_req;
    end
endmodule : bcs_analog_model

// ===== tb/buck_control_sequencer_test.sv
// self-checking bench for the buck control sequencer
module buck_control_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    import bcs_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic enable_pin = 1'b0;
    logic vsel = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic pok;
    logic oe_b;
    logic droop = 1'b0;
    logic clamp = 1'b0;
    logic idle_req = 1'b0;
    bcs_sense_t sns;
    bcs_drive_t drv;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    bcs_sequencer u_dut (.clk(clk), .rst_b(rst_b), .ce(ce),
        .enable_pin(enable_pin), .vsel(vsel), .sense(sns),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .power_ok_output_o(pok), .power_ok_output_oe_b(oe_b),
        .drive(drv));
    bcs_analog_model u_model (.clk(clk), .drive(drv), .droop(droop),
        .clamp(clamp), .idle_req(idle_req), .sense(sns));
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    // hang guard: whole run is about 92000 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles >= 110000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        // waits for ack; if ack never comes only the bench hang guard ends this wait
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, {24'h0, d}, q);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, {24'h0, e});
    endtask : rd
    task automatic pok_bit(input logic e);
        logic [31:0] q;
        wb(1'b0, ADR_STATUS, 32'h0, q);
        chk(32'(q[F_PGOOD]), 32'(e));
    endtask : pok_bit
    task automatic ticks(input int n);
        repeat (n) @(posedge clk);
    endtask : ticks
    task automatic wait_pok(input logic lvl, input int lo, input int hi);
        int n;
        n = 0;
        while (oe_b !== lvl && n <= hi) begin
            @(posedge clk);
            n++;
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask : wait_pok
    task automatic wait_tgt(input logic [7:0] t, output int n);
        n = 0;
        while (drv.target !== t && n < 1000) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_tgt
    task automatic t_reset;
        rd(ADR_RAMP, 8'h04);
        rd(ADR_PGCFG, 8'h01);
        rd(ADR_CTRL, 8'h19);
        rd(8'h10, 8'h00);
        pok_bit(1'b0);
        chk(32'(drv.bleed), 32'h1);
        chk(32'(drv.wide_band_hint), 32'h0);
        chk(32'(pok), 32'h0);
        $display("test reset values done");
    endtask : t_reset
    task automatic t_start;
        int n;
        wr(ADR_RAMP, 8'h00);
        wr(ADR_TGT_A, 8'h05);
        wr(ADR_CTRL, 8'h0B);
        ticks(200);
        chk(32'(drv.running), 32'h0);
        chk(32'(drv.bleed), 32'h1);
        enable_pin <= 1'b1;
        ticks(39800);
        chk({24'h0, drv.target}, 32'h0);
        chk(32'(oe_b), 32'h0);
        wait_tgt(8'h01, n);
        chk(32'(n >= 150 && n <= 450), 32'h1);
        chk(32'(drv.pulse_skipping_mode), 32'h1);
        chk(32'(drv.forced_continuous_mode), 32'h0);
        wait_tgt(8'h02, n);
        chk(32'(n >= 199 && n <= 201), 32'h1);
        wait_tgt(8'h05, n);
        chk({24'h0, drv.target}, 32'h5);
        wait_pok(1'b1, 12750, 13050);
        pok_bit(1'b1);
        chk(32'(drv.pulse_skipping_mode), 32'h0);
        chk(32'(drv.forced_continuous_mode), 32'h1);
        chk(32'(drv.bleed), 32'h0);
        $display("test start-up done");
    endtask : t_start
    task automatic t_retarget;
        logic ok;
        ok = 1'b1;
        wr(ADR_TGT_A, 8'h03);
        repeat (300) begin
            @(posedge clk);
            if (oe_b !== 1'b1) ok = 1'b0;
        end
        chk(32'(ok), 32'h1);
        chk({24'h0, drv.target}, 32'h3);
        wr(ADR_TGT_B, 8'h07);
        wr(ADR_CTRL, 8'h0D);
        vsel <= 1'b1;
        ticks(4);
        chk(32'(oe_b), 32'h0);
        chk({24'h0, drv.target}, 32'h7);
        chk(32'(drv.forced_continuous_mode), 32'h1);
        wait_pok(1'b1, 12700, 13000);
        wr(ADR_PGCFG, 8'h00);
        ticks(3);
        chk(32'(oe_b), 32'h0);
        pok_bit(1'b1);
        wr(ADR_PGCFG, 8'h01);
        ticks(3);
        chk(32'(oe_b), 32'h1);
        $display("test retarget and polarity done");
    endtask : t_retarget
    task automatic t_quiet;
        int n;
        wr(ADR_CTRL, 8'h29);
        ticks(3);
        chk(32'(drv.forced_continuous_mode), 32'h0);
        for (int i = 0; i < 2; i++) begin
            wr(ADR_RAMP, i == 0 ? 8'h00 : 8'h40);
            idle_req <= 1'b1;
            n = 0;
            while (drv.force_sync_on !== 1'b1 && n < 5000) begin
                @(posedge clk);
                n++;
            end
            n = n - (i == 0 ? ARM_SHORT_CYC : ARM_LONG_CYC);
            chk(32'(n >= -10 && n <= 10), 32'h1);
            idle_req <= 1'b0;
            ticks(5);
        end
        $display("test quiet audio done");
    endtask : t_quiet
    task automatic t_droop_fault;
        // two dips that together outlast the de-glitch must not drop it
        repeat (2) begin
            droop <= 1'b1;
            ticks(7000);
            droop <= 1'b0;
            ticks(10);
        end
        chk(32'(oe_b), 32'h1);
        clamp <= 1'b1;
        ticks(3900);
        chk(32'(oe_b), 32'h1);
        wait_pok(1'b0, 50, 150);
        chk(32'(drv.running), 32'h0);
        chk(32'(drv.bleed), 32'h1);
        pok_bit(1'b0);
        $display("test droop and fault done");
    endtask : t_droop_fault
    initial begin
        ticks(16);
        rst_b <= 1'b1;
        t_reset();
        t_start();
        t_retarget();
        t_quiet();
        t_droop_fault();
        test_done();
    end
endmodule : buck_control_sequencer_test
